// file: verilog/sleep_ctrl_pkg.sv
package sleep_ctrl_pkg;

  // ==========================================================
  // Register map (byte addresses on APB)
  localparam logic [7:0] SLEEP_CTRL_OFS = 8'h00;  // sleep_mode_control_reg
  localparam logic [7:0] CORE_CTRL_OFS  = 8'h04;  // core_control_reg
  localparam logic [7:0] COMP_CTRL_OFS  = 8'h08;  // comparator_ctrl_status_reg
  localparam logic [7:0] STATUS_OFS     = 8'h0c;  // Sleep controller status, read only

  // ==========================================================
  // Field positions
  localparam int SLEEP_EN_BIT  = 0;  // sleep_enable_bit
  localparam int MODE_SEL_LSB  = 1;  // sleep_mode_select, three bits
  localparam int DET_KEY_BIT   = 5;  // Timed-write enable for brownout_sleep_disable
  localparam int DET_OFF_BIT   = 6;  // brownout_sleep_disable
  localparam int COMP_OFF_BIT  = 7;  // comparator_off_bit
  localparam int STAT_DET_BIT  = 4;  // Status: brownout_detector enabled
  localparam int STAT_MODE_LSB = 5;  // Status: mode latched at entry

  // ==========================================================
  // Sleep modes and controller states
  typedef enum logic [2:0] {
    MODE_IDLE = 3'h0,
    MODE_ANR  = 3'h1,
    MODE_PD   = 3'h2,
    MODE_PS   = 3'h3,
    MODE_SB   = 3'h6,
    MODE_ESB  = 3'h7
  } sleep_mode_t;

  typedef enum logic [3:0] {
    ST_ACTIVE = 4'b0001,
    ST_SLEEP  = 4'b0010,
    ST_START  = 4'b0100,
    ST_HALT   = 4'b1000
  } ctl_state_t;

  // ==========================================================
  // Timing
  localparam int CNT_W        = 12;
  localparam int CLK_FREQ_MHZ = 40;  // ref_clk rate
  localparam int DET_WAKE_US  = 60;  // Wake extension after software detector-off
  localparam int DET_WAKE_CYC = DET_WAKE_US * CLK_FREQ_MHZ;
  localparam logic [CNT_W-1:0] DET_WAKE_CNT = CNT_W'(DET_WAKE_CYC);  // Must fit the wake counter
  localparam logic [CNT_W-1:0] HALT_CNT     = 12'h004;  // Core hold after start-up
  localparam logic [CNT_W-1:0] STANDBY_CNT  = 12'h006;  // Oscillator kept running
  localparam logic [CNT_W-1:0] STARTUP_CNT  = 12'h006;  // Oscillator restart
  localparam logic [2:0]       DET_KEY_WIN  = 3'h4;     // Timed-write window

  // ==========================================================
  // Whole controller state
  typedef struct packed {
    ctl_state_t       state;
    logic [2:0]       modeSel;
    logic             sleepEn;
    logic [2:0]       modeAct;
    logic             detOffReq;
    logic             detKey;
    logic [2:0]       detKeyWin;
    logic             compOff;
    logic             detOff;
    logic [CNT_W-1:0] cnt;
    logic [31:0]      rdata;
    logic             cpuEn;
    logic             flashEn;
    logic             ioEn;
    logic             adcEn;
    logic             asyEn;
    logic             mainEn;
    logic             tmrEn;
    logic             detEn;
    logic             compEn;
    logic             adcStart;
    logic             wakeIrq;
    logic             rstVec;
  } ctl_t;

  localparam ctl_t CTL_RST = '{state: ST_ACTIVE, modeSel: 3'h0, sleepEn: 1'b0, modeAct: 3'h0,
                               detOffReq: 1'b0, detKey: 1'b0, detKeyWin: 3'h0, compOff: 1'b0,
                               detOff: 1'b0, cnt: 12'h000, rdata: 32'h0000_0000,
                               cpuEn: 1'b1, flashEn: 1'b1, ioEn: 1'b1, adcEn: 1'b1,
                               asyEn: 1'b1, mainEn: 1'b1, tmrEn: 1'b0, detEn: 1'b1,
                               compEn: 1'b1, adcStart: 1'b0, wakeIrq: 1'b0, rstVec: 1'b0};

endpackage

// file: verilog/sleep_mode_clock_gating.sv
// Design decisions made here: the APB register port and the register addresses.
module sleep_mode_clock_gating
  import sleep_ctrl_pkg::*;
(
  input  wire logic        ref_clk,          // System clock
  input  wire logic        rst_n,            // Asynchronous reset
  input  wire logic        psel,             // APB select
  input  wire logic        penable,          // APB access phase
  input  wire logic        pwrite,           // APB direction
  input  wire logic [7:0]  paddr,            // APB byte address
  input  wire logic [31:0] pwdata,           // APB write data
  output logic      [31:0] prdata,           // APB read data
  output logic             pready,           // APB ready
  output logic             pslverr,          // APB error
  input  wire logic        sleepInstr,       // Core executes sleep, one cycle
  input  wire logic        resetReq,         // Reset source while running or asleep
  input  wire logic        irqLineA,         // external_irq_line_a level form
  input  wire logic        irqLineB,         // external_irq_line_b level form
  input  wire logic        irqEdgeA,         // external_irq_line_a edge form
  input  wire logic        irqEdgeB,         // external_irq_line_b edge form
  input  wire logic        pinChangeIrq,     // Pin change
  input  wire logic        twoWireMatchIrq,  // two_wire_port address match
  input  wire logic        watchdogIrq,      // Watchdog
  input  wire logic        asyncTimerIrq,    // async_timer overflow or compare
  input  wire logic        storeReadyIrq,    // self_program_store / EEPROM ready
  input  wire logic        adcDoneIrq,       // Conversion complete
  input  wire logic        comparatorIrq,    // Analog comparator
  input  wire logic        internalIrq,      // Other internal sources
  input  wire logic        asyncTimerAsync,  // async_timer on its own oscillator
  input  wire logic        adcEnabled,       // Converter switched on
  output logic             cpuClkEn,         // cpu_clock_domain
  output logic             flashClkEn,       // program_memory_clock_domain
  output logic             ioClkEn,          // peripheral_clock_domain
  output logic             adcClkEn,         // converter_clock_domain
  output logic             asyncClkEn,       // async_clock_domain
  output logic             mainOscEn,        // Main clock source
  output logic             timerOscEn,       // Timer oscillator
  output logic             detEn,            // brownout_detector on
  output logic             compPowerEn,      // Comparator powered
  output logic             adcStartConv,     // Start conversion pulse
  output logic             wakeIrq,          // Core runs handler, pulse
  output logic             resetVector,      // Core starts at reset vector, pulse
  output logic             sleeping          // Core held
);

  // ==========================================================
  // State
  ctl_t        s_r;       // Registered state
  ctl_t        s_nxt;     // Next state
  sleep_mode_t selMode;   // Mode chosen by software
  sleep_mode_t actMode;   // Mode entered
  logic        setupPh;   // APB setup cycle
  logic        wrAcc;     // APB write, takes effect
  logic        hit;       // Address mapped
  logic        legal;     // Select code names a mode
  logic        deepMode;  // Mode allows detector-off
  logic        wakeNow;   // Wake condition for entered mode
  logic        lvlWake;   // Sources common to every mode
  logic        asyWake;   // Async timer source

  assign selMode = sleep_mode_t'(s_r.modeSel);
  assign actMode = sleep_mode_t'(s_r.modeAct);

  // ==========================================================
  // APB slave: read data latched in setup, one wait-free access
  assign setupPh = psel && !penable;
  assign pready  = psel && penable;
  assign hit     = (paddr == SLEEP_CTRL_OFS) || (paddr == CORE_CTRL_OFS) ||
                   (paddr == COMP_CTRL_OFS) || (paddr == STATUS_OFS);
  assign pslverr = pready && !hit;
  assign wrAcc   = pready && pwrite && hit;
  assign prdata  = s_r.rdata;

  // ==========================================================
  // Mode decode
  always_comb begin
    legal    = 1'b0;
    deepMode = 1'b0;
    unique case (s_r.modeSel)
      MODE_IDLE, MODE_ANR: begin
        legal = 1'b1;
      end
      MODE_PD, MODE_PS, MODE_SB, MODE_ESB: begin
        legal    = 1'b1;
        deepMode = 1'b1;
      end
      default: begin  // Codes 100, 101 are reserved
        legal = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Wake sources per mode
  // Edge forms of the external lines need the peripheral clock,
  // so only the level form reaches past Idle.
  assign lvlWake = irqLineA || irqLineB || pinChangeIrq || twoWireMatchIrq || watchdogIrq;
  assign asyWake = asyncTimerIrq && asyncTimerAsync;

  always_comb begin
    wakeNow = 1'b0;
    unique case (s_r.modeAct)
      MODE_IDLE: begin
        wakeNow = lvlWake || irqEdgeA || irqEdgeB || asyncTimerIrq || storeReadyIrq ||
                  adcDoneIrq || internalIrq || (comparatorIrq && !s_r.compOff);
      end
      MODE_ANR: begin
        wakeNow = lvlWake || asyWake || storeReadyIrq || adcDoneIrq;
      end
      MODE_PS, MODE_ESB: begin
        wakeNow = lvlWake || asyWake;
      end
      default: begin  // Power-down, standby
        wakeNow = lvlWake;
      end
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt          = s_r;
    s_nxt.adcStart = 1'b0;
    s_nxt.wakeIrq  = 1'b0;
    s_nxt.rstVec   = 1'b0;

    // Read mux, sampled in the setup cycle
    if (setupPh) begin
      s_nxt.rdata = 32'h0000_0000;
      unique case (paddr)
        SLEEP_CTRL_OFS: begin
          s_nxt.rdata[SLEEP_EN_BIT]               = s_r.sleepEn;
          s_nxt.rdata[MODE_SEL_LSB +: 3]          = s_r.modeSel;
        end
        CORE_CTRL_OFS: begin
          s_nxt.rdata[DET_OFF_BIT] = s_r.detOffReq;
          s_nxt.rdata[DET_KEY_BIT] = s_r.detKey;
        end
        COMP_CTRL_OFS: begin
          s_nxt.rdata[COMP_OFF_BIT] = s_r.compOff;
        end
        STATUS_OFS: begin
          s_nxt.rdata[3:0]                = s_r.state;
          s_nxt.rdata[STAT_DET_BIT]       = s_r.detEn;
          s_nxt.rdata[STAT_MODE_LSB +: 3] = s_r.modeAct;
        end
        default: begin  // Unmapped reads zero
          s_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Timed-write window counts down and closes by itself
    if (s_r.detKeyWin != 3'h0) begin
      s_nxt.detKeyWin = s_r.detKeyWin - 3'h1;
      if (s_r.detKeyWin == 3'h1) begin
        s_nxt.detKey = 1'b0;
      end
    end

    // Register writes
    if (wrAcc) begin
      unique case (paddr)
        SLEEP_CTRL_OFS: begin
          s_nxt.sleepEn = pwdata[SLEEP_EN_BIT];
          s_nxt.modeSel = pwdata[MODE_SEL_LSB +: 3];
        end
        CORE_CTRL_OFS: begin
          // Arm: both bits written one; a rewrite inside the window
          // neither extends nor clears it.
          if (pwdata[DET_OFF_BIT] && pwdata[DET_KEY_BIT]) begin
            if (!s_r.detKey) begin
              s_nxt.detKey    = 1'b1;
              s_nxt.detKeyWin = DET_KEY_WIN;
            end
          end else if (s_r.detKey && !pwdata[DET_KEY_BIT]) begin
            s_nxt.detOffReq = pwdata[DET_OFF_BIT];
            s_nxt.detKey    = 1'b0;
            s_nxt.detKeyWin = 3'h0;
          end
        end
        COMP_CTRL_OFS: begin
          s_nxt.compOff = pwdata[COMP_OFF_BIT];
        end
        default: begin  // Status is read only
          s_nxt.compOff = s_r.compOff;
        end
      endcase
    end

    // Sleep sequencing; memories are never touched here
    unique case (s_r.state)
      ST_ACTIVE: begin
        // No enable or reserved code: instruction is a no-op
        if (sleepInstr && s_r.sleepEn && legal) begin
          s_nxt.state   = ST_SLEEP;
          s_nxt.modeAct = s_r.modeSel;
          s_nxt.detOff  = s_r.detOffReq && deepMode;
          if (adcEnabled && (selMode == MODE_IDLE || selMode == MODE_ANR)) begin
            s_nxt.adcStart = 1'b1;
          end
        end
      end
      ST_SLEEP: begin
        if (wakeNow) begin
          s_nxt.state  = ST_START;
          s_nxt.detOff = 1'b0;
          unique case (actMode)
            MODE_SB, MODE_ESB: s_nxt.cnt = STANDBY_CNT;
            MODE_PD, MODE_PS:  s_nxt.cnt = STARTUP_CNT;
            default:           s_nxt.cnt = '0;
          endcase
          if (s_r.detOff) begin
            s_nxt.cnt = s_nxt.cnt + DET_WAKE_CNT;
          end
        end
      end
      ST_START: begin
        if (s_r.cnt == '0) begin
          s_nxt.state = ST_HALT;
          s_nxt.cnt   = HALT_CNT - 12'h001;
        end else begin
          s_nxt.cnt = s_r.cnt - 12'h001;
        end
      end
      ST_HALT: begin
        if (s_r.cnt == '0) begin
          s_nxt.state   = ST_ACTIVE;
          s_nxt.wakeIrq = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt - 12'h001;
        end
      end
    endcase

    // Reset source overrides any sleep step
    if (resetReq) begin
      s_nxt.state  = ST_ACTIVE;
      s_nxt.rstVec = 1'b1;
      s_nxt.detOff = 1'b0;
      s_nxt.cnt    = '0;
    end

    // Clock gating from the next state
    s_nxt.detEn  = !s_nxt.detOff;
    s_nxt.compEn = !s_nxt.compOff;
    s_nxt.tmrEn  = asyncTimerAsync;
    s_nxt.cpuEn  = (s_nxt.state == ST_ACTIVE);
    s_nxt.flashEn = (s_nxt.state == ST_ACTIVE);
    s_nxt.ioEn   = 1'b1;
    s_nxt.adcEn  = 1'b1;
    s_nxt.asyEn  = 1'b1;
    s_nxt.mainEn = 1'b1;
    if (s_nxt.state == ST_SLEEP) begin
      s_nxt.cpuEn   = 1'b0;
      s_nxt.flashEn = 1'b0;
      unique case (sleep_mode_t'(s_nxt.modeAct))
        MODE_IDLE: begin
          s_nxt.tmrEn = asyncTimerAsync;
        end
        MODE_ANR: begin
          s_nxt.ioEn  = 1'b0;
          s_nxt.asyEn = asyncTimerAsync;
        end
        MODE_PD: begin
          s_nxt.ioEn   = 1'b0;
          s_nxt.adcEn  = 1'b0;
          s_nxt.asyEn  = 1'b0;
          s_nxt.mainEn = 1'b0;
          s_nxt.tmrEn  = 1'b0;
        end
        MODE_SB: begin
          s_nxt.ioEn  = 1'b0;
          s_nxt.adcEn = 1'b0;
          s_nxt.asyEn = 1'b0;
          s_nxt.tmrEn = 1'b0;
        end
        default: begin  // Power-save, extended standby
          s_nxt.ioEn   = 1'b0;
          s_nxt.adcEn  = 1'b0;
          s_nxt.asyEn  = asyncTimerAsync;
          s_nxt.mainEn = (sleep_mode_t'(s_nxt.modeAct) == MODE_ESB);
        end
      endcase
      s_nxt.compEn = s_nxt.compEn && (sleep_mode_t'(s_nxt.modeAct) == MODE_IDLE);
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= CTL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from flip-flops, sleeping decoded from the state register
  assign cpuClkEn     = s_r.cpuEn;
  assign flashClkEn   = s_r.flashEn;
  assign ioClkEn      = s_r.ioEn;
  assign adcClkEn     = s_r.adcEn;
  assign asyncClkEn   = s_r.asyEn;
  assign mainOscEn    = s_r.mainEn;
  assign timerOscEn   = s_r.tmrEn;
  assign detEn        = s_r.detEn;
  assign compPowerEn  = s_r.compEn;
  assign adcStartConv = s_r.adcStart;
  assign wakeIrq      = s_r.wakeIrq;
  assign resetVector  = s_r.rstVec;
  assign sleeping     = (s_r.state != ST_ACTIVE);

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence enterReq;
    s_r.state == ST_ACTIVE && sleepInstr && !resetReq;
  endsequence

  sequence haltEntry;
    s_r.state != ST_HALT ##1 s_r.state == ST_HALT && !resetReq;
  endsequence

  a_sleep_entry: assert property (enterReq and s_r.sleepEn && legal |=> s_r.state == ST_SLEEP)
    else $error("Enabled sleep not entered");
  a_no_enable: assert property (enterReq and !s_r.sleepEn |=> s_r.state == ST_ACTIVE && cpuClkEn)
    else $error("Sleep entered without enable");
  a_reserved_code: assert property (enterReq and s_r.modeSel[2:1] == 2'b10 |=> s_r.state == ST_ACTIVE)
    else $error("Reserved code entered sleep");
  a_idle_clocks: assert property (s_r.state == ST_SLEEP && actMode == MODE_IDLE
                                  |-> !cpuClkEn && !flashClkEn && ioClkEn && adcClkEn && mainOscEn)
    else $error("Idle gating wrong");
  a_pd_all_off: assert property (s_r.state == ST_SLEEP && actMode == MODE_PD
                                 |-> !(ioClkEn || adcClkEn || asyncClkEn || mainOscEn || timerOscEn))
    else $error("Power-down left a clock on");
  // Four halt samples, then the handler pulse shows one edge later
  a_halt_four: assert property (haltEntry ##0 (!resetReq)[*4] |=> s_r.state == ST_ACTIVE && wakeIrq)
    else $error("Halt not four cycles");
  a_det_off: assert property (enterReq and s_r.sleepEn && s_r.detOffReq && selMode == MODE_PD |=> !detEn)
    else $error("Detector not switched off");
  a_det_idle_on: assert property (enterReq and s_r.sleepEn && selMode == MODE_IDLE |=> detEn)
    else $error("Detector off in Idle");
  a_det_back: assert property (s_r.state != ST_SLEEP |-> detEn)
    else $error("Detector still off after wake");
  a_det_delay: assert property (s_r.state == ST_SLEEP && s_r.detOff && wakeNow && !resetReq && actMode == MODE_PD
                                |=> s_r.cnt == STARTUP_CNT + DET_WAKE_CNT)
    else $error("Detector wake extension wrong");
  a_standby_six: assert property (s_r.state == ST_SLEEP && !s_r.detOff && wakeNow && !resetReq && actMode == MODE_SB
                                  |=> s_r.cnt == STANDBY_CNT)
    else $error("Standby wake count wrong");
  a_adc_start: assert property (enterReq and s_r.sleepEn && selMode == MODE_IDLE && adcEnabled |=> adcStartConv)
    else $error("Conversion not started");
  a_reset_vec: assert property (resetReq |=> resetVector && s_r.state == ST_ACTIVE)
    else $error("Reset did not restart core");

endmodule  // sleep_mode_clock_gating

// file: testbench/core_model.sv
// ==========================================================
// Core side: issues the sleep instruction on request
module core_model (
  input  wire logic ref_clk,    // System clock
  input  wire logic rst_n,      // Asynchronous reset
  input  wire logic goSleep,    // Bench asks for a sleep instruction
  input  wire logic sleeping,   // Core held by the controller
  input  wire logic wakeIrq,    // Handler entry pulse
  input  wire logic resetVector,  // Restart pulse
  output logic      sleepInstr, // One-cycle sleep instruction
  output int        wakes       // Handler entries seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // One-cycle pulses, never back to back or while held: a halted core fetches nothing
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleepInstr <= 1'b0;
      wakes      <= 0;
    end else begin
      sleepInstr <= goSleep && !sleeping && !sleepInstr;
      if (wakeIrq) begin  // Resume after sleep through the handler
        wakes <= wakes + 1;
      end
      if (resetVector) begin  // Restart discards resume point
        wakes <= 0;
      end
    end
  end
endmodule  // core_model

// file: testbench/test_sleep_mode_clock_gating.sv
// ==========================================================
// Bench top
module test_sleep_mode_clock_gating;
  timeunit 1ns;
  timeprecision 1ps;
  import sleep_ctrl_pkg::*;
  logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;    // APB address
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, resetReq = 1'b0, goSleep = 1'b0, sleepInstr;
  logic [11:0] irq = 12'h000;    // Wake request lines
  logic        async = 1'b0, adcOn = 1'b0;
  logic        cpuClkEn, flashClkEn, ioClkEn, adcClkEn, asyncClkEn, mainOscEn, timerOscEn;
  logic        detEn, compPowerEn, adcStartConv, wakeIrq, resetVector, sleeping;
  logic [15:0] lfsr = 16'h95d0;  // Fixed seed
  // Standby codes are used only as if a crystal source were fitted
  logic [2:0]  modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  int          srcs [6] = '{0, 2, 11, 5, 6, 7};  // Wake source per mode
  int          err_total = 0, checks = 0, n, wakes;
  always #12.5 ref_clk = ~ref_clk;
  sleep_mode_clock_gating dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleepInstr(sleepInstr), .resetReq(resetReq), .irqLineA(irq[11]),
    .irqLineB(irq[10]), .irqEdgeA(irq[9]), .irqEdgeB(irq[8]), .pinChangeIrq(irq[7]),
    .twoWireMatchIrq(irq[6]), .watchdogIrq(irq[5]), .asyncTimerIrq(irq[4]),
    .storeReadyIrq(irq[3]), .adcDoneIrq(irq[2]), .comparatorIrq(irq[1]), .internalIrq(irq[0]),
    .asyncTimerAsync(async), .adcEnabled(adcOn), .cpuClkEn(cpuClkEn), .flashClkEn(flashClkEn),
    .ioClkEn(ioClkEn), .adcClkEn(adcClkEn), .asyncClkEn(asyncClkEn), .mainOscEn(mainOscEn),
    .timerOscEn(timerOscEn), .detEn(detEn), .compPowerEn(compPowerEn),
    .adcStartConv(adcStartConv), .wakeIrq(wakeIrq), .resetVector(resetVector),
    .sleeping(sleeping));
  core_model core (.ref_clk(ref_clk), .rst_n(rst_n), .goSleep(goSleep), .sleeping(sleeping),
    .wakeIrq(wakeIrq), .resetVector(resetVector), .sleepInstr(sleepInstr), .wakes(wakes));
  // ==========================================================
  // Expectations
  function automatic logic [6:0] clocks(logic [2:0] m, logic a);  // cpu flash io adc asy main tmr
    case (m)
      3'h0:    clocks = {4'b0011, 2'b11, a};
      3'h1:    clocks = {4'b0001, a, 1'b1, a};
      3'h3:    clocks = {4'b0000, a, 1'b0, a};
      3'h6:    clocks = 7'h02;
      3'h7:    clocks = {4'b0000, a, 1'b1, a};
      default: clocks = 7'h00;
    endcase
  endfunction
  // Edges from wake request to handler pulse
  function automatic int wakeLat(logic [2:0] m, logic detOff);
    wakeLat = 6 + ((m > 3'h1) ? 6 : 0) + (detOff ? 2400 : 0);
  endfunction
  // Next value of the stimulus shift register
  function automatic logic [15:0] nextLfsr(logic [15:0] v);
    nextLfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // ==========================================================
  // Shared tasks
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // APB transfer: held until pready is sampled high
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic doSleep();
    @(posedge ref_clk) goSleep <= 1'b1;
    @(posedge ref_clk) goSleep <= 1'b0;
    @(posedge ref_clk) #1;
  endtask
  // Raise one wake source and count edges until the handler pulse
  task automatic wake(int s);
    @(posedge ref_clk) irq <= 12'h001 << s;
    n = 0;
    do begin @(posedge ref_clk); #1; n++; end while (wakeIrq !== 1'b1 && n < 3000);
    irq <= 12'h000;
  endtask
  task automatic final_report();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin  // Watchdog
    #(20000 * 25);
    err_total++;
    final_report();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status", rd, 32'h11);
    apb(1'b0, CORE_CTRL_OFS, 32'h0);
    chk("sleep-off reset", rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    apb(1'b1, SLEEP_CTRL_OFS, 32'h4);
    doSleep();
    chk("no enable", sleeping, 1'b0);
    for (int m = 4; m < 6; m++) begin  // Reserved codes
      apb(1'b1, SLEEP_CTRL_OFS, 32'(m * 2 + 1));
      doSleep();
      chk("reserved", sleeping, 1'b0);
    end
    foreach (modes[i]) begin
      lfsr = nextLfsr(lfsr);
      async <= lfsr[0]; adcOn <= lfsr[1];
      apb(1'b1, SLEEP_CTRL_OFS, {28'h0, modes[i], 1'b1});
      doSleep();
      chk("sleeping", sleeping, 1'b1);
      chk("clocks", {cpuClkEn, flashClkEn, ioClkEn, adcClkEn, asyncClkEn, mainOscEn, timerOscEn},
          clocks(modes[i], async));
      chk("conv", adcStartConv, adcOn && i < 2);
      if (i == 2) begin  // Edge form of line A and store-ready must not wake power-down
        irq <= 12'h208;
        repeat (8) @(posedge ref_clk);
        #1 chk("no wake", sleeping, 1'b1);
        irq <= 12'h000;
      end
      wake(srcs[i]);
      chk("wake time", n, wakeLat(modes[i], 1'b0));
      chk("cpu back", {cpuClkEn, detEn}, 2'b11);
    end
    apb(1'b1, CORE_CTRL_OFS, 32'h40);
    apb(1'b0, CORE_CTRL_OFS, 32'h0);
    chk("untimed", rd[6], 1'b0);
    apb(1'b1, CORE_CTRL_OFS, 32'h60);
    apb(1'b1, CORE_CTRL_OFS, 32'h40);
    apb(1'b0, CORE_CTRL_OFS, 32'h0);
    chk("timed", rd[6], 1'b1);
    apb(1'b1, SLEEP_CTRL_OFS, 32'h5);
    doSleep();
    chk("detector off", detEn, 1'b0);
    wake(10);
    chk("detector wake", n, wakeLat(3'h2, 1'b1));
    chk("detector on", detEn, 1'b1);
    apb(1'b1, COMP_CTRL_OFS, 32'h80);
    #1 chk("comp off", compPowerEn, 1'b0);
    apb(1'b1, SLEEP_CTRL_OFS, 32'h1);
    doSleep();
    chk("idle detector", detEn, 1'b1);
    irq <= 12'h002;
    repeat (8) @(posedge ref_clk);
    #1 chk("comp wake", sleeping, 1'b1);
    irq <= 12'h000;
    chk("handler entries", wakes, 32'd7);
    @(posedge ref_clk) resetReq <= 1'b1;
    @(posedge ref_clk) resetReq <= 1'b0;
    #1 chk("reset wake", {resetVector, sleeping, wakeIrq}, 3'b100);
    // The core sees the restart pulse one edge later
    @(posedge ref_clk) #1 chk("resume dropped", wakes, 32'd0);
    final_report();
  end
endmodule  // test_sleep_mode_clock_gating
